/* File: ext_bus_ctrl.sv */
// Purpose: Wait insertion and internal/external decode for the expansion bus
// Assumes: One CPU request at a time, held until done_o; inputs synchronous
// Notes:   Access runs addr (1 clk), strobe (1 clk + waits), end (1 clk)
`default_nettype none
module ext_bus_ctrl
   import ext_bus_pkg::*;
#(
   parameter logic [19:0] ROM_TOP    = 20'h1FFFF,
   parameter logic [15:0] RAM_BASE   = 16'hDF00,
   parameter logic [19:0] PERI_LO    = 20'h00000,
   parameter logic [19:0] PERI_HI    = 20'h00000,
   parameter bit          PERI_EN    = 1'b0
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire cpu_req_t    req_i,
   input  wire logic [3:0]  reloc_i,
   input  wire logic        reloc_we_i,
   input  wire logic        wait_n_i,
   output logic             done_o,
   output logic [7:0]       rdata_o,
   output logic             int_sel_o,
   output logic             addr_latch_strobe_o,
   output logic             rd_n_o,
   output logic             wr_n_o,
   output logic [19:0]      addr_o,
   output logic [7:0]       ad_o,
   output logic             ad_oe_o,
   input  wire logic [7:0]  ad_i
);
   // Refuse a RAM base that would swallow the register space
   if (RAM_BASE >= SFR_LO) begin : g_bad_ram_base
      $error("RAM_BASE must lie below register space");
   end

   // Internal resource decode; external register window always goes out
   function automatic logic is_internal(input logic [19:0] a,
                                        input logic [3:0] rb);
      logic in_bank;
      logic [15:0] lo;
      in_bank = (a[19:16] == rb);
      lo = a[15:0];
      if (in_bank && lo >= EXT_SFR_LO && lo <= EXT_SFR_HI)
         return 1'b0;
      if (in_bank && lo >= RAM_BASE) return 1'b1;
      return (a <= ROM_TOP);
   endfunction

   logic [7:0]  wait_cfg;
   logic [7:0]  mode_reg;
   logic [3:0]  reloc;
   bus_state_t  state;
   logic [1:0]  wcnt;
   logic [7:0]  rdata;
   logic        done;
   logic        addr_latch_strobe;
   logic        rd_n;
   logic        wr_n;
   logic [19:0] addr;
   logic [7:0]  ad;
   logic        ad_oe;
   logic [7:0]  next_wait_cfg;
   logic [7:0]  next_mode_reg;
   logic [3:0]  next_reloc;
   bus_state_t  next_state;
   logic [1:0]  next_wcnt;
   logic [7:0]  next_rdata;
   logic        next_done;
   logic        next_addr_latch_strobe;
   logic        next_rd_n;
   logic        next_wr_n;
   logic [19:0] next_addr;
   logic [7:0]  next_ad;
   logic        next_ad_oe;

   logic        active;
   logic        hit_wcfg;
   logic        hit_mode;
   logic        is_int;
   logic        is_rom;
   logic        is_peri;
   logic        use_waits;
   wait_sel_t   wsel;
   logic [19:0] amask;
   logic [3:0]  mode_sel;

   assign active   = (req_i.rd | req_i.wr) & ~done;
   assign hit_wcfg = (req_i.addr[15:0] == WAIT_CFG_ADDR[15:0]) &&
                     (req_i.addr[19:16] == reloc);
   assign hit_mode = (req_i.addr[15:0] == MODE_REG_ADDR[15:0]) &&
                     (req_i.addr[19:16] == reloc);
   assign is_int   = is_internal(req_i.addr, reloc);
   // RAM and registers of the mapped bank are never ROM, even below ROM_TOP
   assign is_rom   = (req_i.addr <= ROM_TOP) &&
                     !((req_i.addr[19:16] == reloc) &&
                       (req_i.addr[15:0] >= RAM_BASE));
   assign is_peri  = PERI_EN && req_i.addr >= PERI_LO &&
                     req_i.addr <= PERI_HI;
   assign wsel     = wait_sel_t'(wait_cfg[1:0]);
   assign mode_sel = {mode_reg[MODE_TOP_BIT], 2'b00, mode_reg[MODE_BOT_BIT]};
   // Slow ROM fetch borrows external timing but strobes stay idle
   assign use_waits = ~is_peri &&
                      (~is_int || (is_rom && !mode_reg[MODE_FAST_FETCH_BIT]));
   // Mask upper address bits unless in 1-Mbyte mode
   assign amask = (mode_sel == MODE_1M) ? MASK_1M : MASK_256K;

   // Next state of registers, bus pins and access sequencer
   always_comb begin
      next_wait_cfg = wait_cfg;
      next_mode_reg = mode_reg;
      next_reloc    = reloc;
      next_state    = state;
      next_wcnt     = wcnt;
      next_rdata    = rdata;
      next_done     = 1'b0;
      next_addr_latch_strobe     = 1'b0;
      next_rd_n     = 1'b1;
      next_wr_n     = 1'b1;
      next_addr     = addr;
      next_ad       = ad;
      next_ad_oe    = 1'b0;
      if (reloc_we_i && (reloc_i == RELOC_BANK0 || reloc_i == RELOC_TOP))
         next_reloc = reloc_i;
      unique case (state)
         ST_IDLE: begin
            if (active) begin
               if (is_int && !use_waits) begin
                  next_state = ST_INT;
               end else if (is_int) begin
                  // Slow ROM keeps the address phase so timing matches
                  next_state = ST_ADDR;
               end else begin
                  next_state = ST_ADDR;
                  next_addr_latch_strobe  = 1'b1;
                  next_addr  = req_i.addr & amask;
                  next_ad    = req_i.addr[7:0];
                  next_ad_oe = 1'b1;
               end
               next_wcnt = (wsel == WAIT_EXT) ? 2'd0 : wsel;
            end
         end
         ST_ADDR: begin
            next_state = ST_STROBE;
            next_rd_n  = is_int | ~req_i.rd;
            next_wr_n  = is_int | ~req_i.wr;
            next_ad    = is_int ? ad : req_i.wdata;
            next_ad_oe = ~is_int & req_i.wr;
         end
         ST_STROBE, ST_WAIT: begin
            next_rd_n  = is_int | ~req_i.rd;
            next_wr_n  = is_int | ~req_i.wr;
            next_ad_oe = ~is_int & req_i.wr;
            if (!use_waits) begin
               next_state = ST_END;
            end else if (wsel == WAIT_EXT) begin
               // Internal ROM under external wait never ends: reset only
               if (is_int || wait_n_i) next_state = is_int ? ST_WAIT : ST_END;
               else next_state = ST_WAIT;
            end else if (wcnt != 2'd0) begin
               next_wcnt  = wcnt - 2'd1;
               next_state = ST_WAIT;
            end else begin
               next_state = ST_END;
            end
            if (next_state == ST_END) begin
               next_rd_n  = 1'b1;
               next_wr_n  = 1'b1;
               next_ad_oe = 1'b0;
               next_rdata = is_int ? 8'h00 : ad_i;
               next_done  = 1'b1;
            end
         end
         ST_INT: begin
            next_state = ST_IDLE;
            next_done  = 1'b1;
            next_rdata = 8'h00;
            if (hit_wcfg) next_rdata = wait_cfg;
            if (hit_mode) next_rdata = mode_reg;
            if (req_i.wr && hit_wcfg) next_wait_cfg = req_i.wdata;
            if (req_i.wr && hit_mode) next_mode_reg = req_i.wdata;
         end
         ST_END: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // Register all state; synchronous reset
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wait_cfg <= WAIT_CFG_RESET;
         mode_reg <= MODE_REG_RESET;
         reloc    <= RELOC_BANK0;
         state    <= ST_IDLE;
         wcnt     <= 2'd0;
         rdata    <= 8'h00;
         done     <= 1'b0;
         addr_latch_strobe     <= 1'b0;
         rd_n     <= 1'b1;
         wr_n     <= 1'b1;
         addr     <= 20'h00000;
         ad       <= 8'h00;
         ad_oe    <= 1'b0;
      end else begin
         wait_cfg <= next_wait_cfg;
         mode_reg <= next_mode_reg;
         reloc    <= next_reloc;
         state    <= next_state;
         wcnt     <= next_wcnt;
         rdata    <= next_rdata;
         done     <= next_done;
         addr_latch_strobe     <= next_addr_latch_strobe;
         rd_n     <= next_rd_n;
         wr_n     <= next_wr_n;
         addr     <= next_addr;
         ad       <= next_ad;
         ad_oe    <= next_ad_oe;
      end
   end

   assign done_o    = done;
   assign rdata_o   = rdata;
   assign int_sel_o = is_int;
   assign addr_latch_strobe_o    = addr_latch_strobe;
   assign rd_n_o    = rd_n;
   assign wr_n_o    = wr_n;
   assign addr_o    = addr;
   assign ad_o      = ad;
   assign ad_oe_o   = ad_oe;
endmodule // ext_bus_ctrl
`default_nettype wire

/* File: ext_bus_pkg.sv */
// Purpose: Shared constants and types for the expansion bus wait/decode block
// Assumes: 20-bit CPU address space, 8-bit data, one system clock
// Notes:   Register offsets are byte addresses in special function space
package ext_bus_pkg;
   localparam int          ADDR_W              = 20;
   localparam int          DATA_W              = 8;
   localparam logic [19:0] WAIT_CFG_ADDR       = 20'h0FFC7;
   localparam logic [19:0] MODE_REG_ADDR       = 20'h0FFC4;
   localparam logic [7:0]  WAIT_CFG_RESET      = 8'hAA;
   localparam logic [7:0]  MODE_REG_RESET      = 8'h20;
   localparam int          MODE_FAST_FETCH_BIT = 7;
   localparam int          MODE_TOP_BIT        = 3;
   localparam int          MODE_BOT_BIT        = 0;
   localparam logic [3:0]  MODE_SINGLE         = 4'h0;
   localparam logic [3:0]  MODE_256K           = 4'h8;
   localparam logic [3:0]  MODE_1M             = 4'h9;
   localparam logic [19:0] MASK_256K           = 20'h3FFFF;
   localparam logic [19:0] MASK_1M             = 20'hFFFFF;
   localparam logic [15:0] EXT_SFR_LO          = 16'hFFD0;
   localparam logic [15:0] EXT_SFR_HI          = 16'hFFDF;
   localparam logic [15:0] SFR_LO              = 16'hFF00;
   localparam logic [3:0]  RELOC_BANK0         = 4'h0;
   localparam logic [3:0]  RELOC_TOP           = 4'hF;
   localparam int          BASE_CYCLES         = 3;

   typedef enum logic [1:0] {
      WAIT_NONE = 2'b00,
      WAIT_ONE  = 2'b01,
      WAIT_TWO  = 2'b10,
      WAIT_EXT  = 2'b11
   } wait_sel_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        fetch;
      logic [19:0] addr;
      logic [7:0]  wdata;
   } cpu_req_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_ADDR   = 3'b001,
      ST_STROBE = 3'b010,
      ST_WAIT   = 3'b011,
      ST_END    = 3'b100,
      ST_INT    = 3'b101
   } bus_state_t;
endpackage : ext_bus_pkg

/* File: ext_bus_ctrl_sva.sv */
// Purpose: Port checker for the bus wait/decode block
// Assumes: One clock, synchronous active-high reset
// Notes:   Internal decode is seen through int_sel_o
`default_nettype none
module ext_bus_ctrl_sva
   import ext_bus_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire cpu_req_t    req_i,
   input wire logic        done_o,
   input wire logic        int_sel_o,
   input wire logic        addr_latch_strobe_o,
   input wire logic        rd_n_o,
   input wire logic        wr_n_o,
   input wire logic [19:0] addr_o,
   input wire logic        ad_oe_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   logic busy_int;
   // A request that the decode keeps inside the device
   assign busy_int = (req_i.rd | req_i.wr) & int_sel_o;
   a_int_no_strobe: assert property (
      busy_int |-> !addr_latch_strobe_o && rd_n_o && wr_n_o)
      else $error("strobe active on internal access");
   a_int_addr_hold: assert property (busy_int |=> $stable(addr_o))
      else $error("address moved on internal access");
   a_int_ad_float: assert property (busy_int |-> !ad_oe_o)
      else $error("data bus driven on internal access");
   a_strobe_end_done: assert property (
      $rose(rd_n_o) || $rose(wr_n_o) |-> done_o)
      else $error("strobe end without done");
   a_addr_latch_strobe_no_done: assert property (addr_latch_strobe_o |=> !addr_latch_strobe_o && !done_o)
      else $error("access shorter than three clocks");
   a_done_pulse: assert property (done_o |=> !done_o)
      else $error("done longer than one clock");
   a_read_bus_free: assert property (!rd_n_o |-> !ad_oe_o)
      else $error("data bus driven during read strobe");
   a_one_strobe: assert property (!rd_n_o |-> wr_n_o)
      else $error("read and write strobes together");
endmodule // ext_bus_ctrl_sva
bind ext_bus_ctrl ext_bus_ctrl_sva u_ext_bus_ctrl_sva (.clk_sys_i(clk_sys_i),
   .rst_i(rst_i), .req_i(req_i), .done_o(done_o), .int_sel_o(int_sel_o),
   .addr_latch_strobe_o(addr_latch_strobe_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .addr_o(addr_o),
   .ad_oe_o(ad_oe_o));
`default_nettype wire

/* File: ext_mem_model.sv */
// Purpose: External memory on the multiplexed address/data bus
// Assumes: Low address byte is on the bus while the latch strobe is high
// Notes:   Read data is the latched byte XOR 5AH
`default_nettype none
module ext_mem_model (
   input  wire logic       clk_sys_i,
   input  wire logic       addr_latch_strobe_i,
   input  wire logic       rd_n_i,
   input  wire logic [7:0] bus_i,
   input  wire logic [3:0] stretch_i,
   output logic [7:0]      data_o,
   output logic            wait_n_o
);
   logic [7:0] low_addr = 8'h00;
   logic [3:0] hold_cnt = 4'h0;
   // Latch the address, then count down the requested stretch
   always @(posedge clk_sys_i) begin
      if (addr_latch_strobe_i) begin
         low_addr <= bus_i;
         hold_cnt <= stretch_i;
      end else if (hold_cnt != 4'h0) begin
         hold_cnt <= hold_cnt - 4'h1;
      end
   end
   assign wait_n_o = (hold_cnt == 4'h0); // Low stretches the cycle
   // Released bus shows the inverse, so stale data never passes
   assign data_o = rd_n_i ? ~(low_addr ^ 8'h5A) : (low_addr ^ 8'h5A);
endmodule // ext_mem_model
`default_nettype wire

/* File: test_external_bus_wait_and_decode.sv */
// Purpose: Self-checking bench for the bus wait/decode block
// Assumes: Model answers reads with the low address XOR 5AH
// Notes:   Inputs change on the falling edge
`default_nettype none
module test_external_bus_wait_and_decode import ext_bus_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_i = 1'b0, rst_i = 1'b1, reloc_we_i = 1'b0;
   logic        wait_n, done, int_sel, addr_latch_strobe, rd_n, wr_n, ad_oe;
   cpu_req_t    req = '0;
   logic [3:0]  reloc = 4'h0, stretch = 4'h2;
   logic [7:0]  rdata, ad_out, ad_in, q;
   logic [7:0]  wbyte = 8'h00;
   logic [19:0] addr;
   int          num_errors = 0, n_checks = 0, cyc, ticks = 0;
   ext_bus_ctrl u_ext_bus_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .req_i(req), .reloc_i(reloc), .reloc_we_i(reloc_we_i),
      .wait_n_i(wait_n), .done_o(done), .rdata_o(rdata), .int_sel_o(int_sel),
      .addr_latch_strobe_o(addr_latch_strobe), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr),
      .ad_o(ad_out), .ad_oe_o(ad_oe), .ad_i(ad_in));
   ext_mem_model u_ext_mem_model (.clk_sys_i(clk_sys_i), .addr_latch_strobe_i(addr_latch_strobe),
      .rd_n_i(rd_n), .bus_i(ad_out), .stretch_i(stretch), .data_o(ad_in),
      .wait_n_o(wait_n));
   initial forever #4 clk_sys_i = ~clk_sys_i;
   // Byte that the device drives while the write strobe is low
   always @(posedge clk_sys_i) if (!wr_n && ad_oe) wbyte <= ad_out;
   task automatic give_verdict;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [19:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One byte access; cyc counts clocks from the taking edge to done
   task automatic access(input logic rd, wr, input logic [19:0] a,
                         input logic [7:0] d);
      cyc = 0;
      @(negedge clk_sys_i);
      req <= '{rd, wr, 1'b0, a, d};
      do begin
         @(posedge clk_sys_i);
         #1 cyc++;
      end while (done !== 1'b1 && cyc < 60);
      if (done !== 1'b1) num_errors++;
      q = rdata;
      @(negedge clk_sys_i);
      req <= '0;
      @(negedge clk_sys_i);
   endtask
   task automatic t_reset_values;
      access(1'b1, 1'b0, WAIT_CFG_ADDR, 8'h00);
      chk(q, WAIT_CFG_RESET);
      access(1'b1, 1'b0, MODE_REG_ADDR, 8'h00);
      chk(q, MODE_REG_RESET);
   endtask
   // Upper bits set and wait input low must not change the count
   task automatic t_wait_codes;
      access(1'b0, 1'b1, MODE_REG_ADDR, {4'h0, MODE_1M});
      for (int w = 0; w < 3; w++) begin
         access(1'b0, 1'b1, WAIT_CFG_ADDR, 8'hFC | 8'(w));
         access(1'b1, 1'b0, WAIT_CFG_ADDR, 8'h00);
         chk(q, 8'hFC | 8'(w));
         access(1'b1, 1'b0, 20'h54321, 8'h00);
         chk(20'(cyc), 20'(BASE_CYCLES + w));
         chk(q, 8'h21 ^ 8'h5A);
         chk(addr, 20'h54321);
      end
   endtask
   task automatic t_ext_wait;
      stretch = 4'h4;
      access(1'b0, 1'b1, WAIT_CFG_ADDR, 8'h03);
      access(1'b1, 1'b0, 20'h54321, 8'h00);
      // The model holds wait low for four sampled strobe clocks
      chk(20'(cyc), 20'(BASE_CYCLES + 4));
      stretch = 4'h2;
   endtask
   // Masking, then an internal access that must leave the pins alone
   task automatic t_decode;
      access(1'b0, 1'b1, WAIT_CFG_ADDR, 8'h01);
      access(1'b0, 1'b1, MODE_REG_ADDR, {4'h0, MODE_256K});
      access(1'b1, 1'b0, 20'h67821, 8'h00);
      chk(addr, 20'h27821);
      chk(20'(cyc), 20'(BASE_CYCLES + 1));
      access(1'b1, 1'b0, 20'h0E000, 8'h00);
      chk(addr, 20'h27821);
      access(1'b1, 1'b0, 20'h0FFD0, 8'h00);
      chk(addr, 20'h0FFD0);
      chk(q, 8'hD0 ^ 8'h5A);
      access(1'b0, 1'b1, 20'h0FFD5, 8'h3C);
      chk(wbyte, 8'h3C);
      chk(20'(cyc), 20'(BASE_CYCLES + 1));
   endtask
   // Internal ROM: external timing while fast fetch is clear, else none
   task automatic t_rom_timing;
      access(1'b1, 1'b0, 20'h01000, 8'h00);
      chk(20'(cyc), 20'(BASE_CYCLES + 1));
      chk(addr, 20'h0FFD5);
      access(1'b0, 1'b1, MODE_REG_ADDR, {4'h8, MODE_256K});
      access(1'b1, 1'b0, 20'h01000, 8'h00);
      chk(20'(cyc), 20'd2);
   endtask
   task automatic t_relocate;
      @(negedge clk_sys_i);
      reloc <= RELOC_TOP;
      reloc_we_i <= 1'b1;
      @(negedge clk_sys_i);
      reloc_we_i <= 1'b0;
      access(1'b1, 1'b0, 20'hFFFC7, 8'h00);
      chk(q, 8'h01);
   endtask
   // Cut a hang short well past the expected run length
   always @(posedge clk_sys_i) begin
      ticks++;
      if (ticks == 3000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_i <= 1'b0;
      t_reset_values();
      t_wait_codes();
      t_ext_wait();
      t_decode();
      t_rom_timing();
      t_relocate();
      give_verdict();
   end
endmodule // test_external_bus_wait_and_decode
`default_nettype wire
